/* File: watchdog_timer.sv */
// Watchdog timer: oscillator-driven binary counter, command decode and register port
//
// How it works
// [R01] Mode bit 7 enables counting
// [R02] Period codes 0-5 select 2^15..2^25 ticks
// [R03] Idle: count only when idle run bit set
// [R04] Overflow: NMI if action 0, reset if 1
// [R05] Command 0xB1 disables, 0x4E clears, others reserved
// [R06] Flag bit 0 shows writes not allowed
// [R07] Counter advances on oscillator edges only
// [R08] Clear code zeroes counter, counting resumes
// [R09] Counting starts right after reset release
// [R10] Counter halts during debug
// [R11] Internal reset held for 32 states
// [R12] Enable cleared then 0xB1 stops and clears
// [R13] Software checks flag before mode writes
// [R14] Software disables before deep sleep modes
// [R15] Overflow interrupt sets NMI cause indication
// [R16] Reserved command values change nothing
// [R17] Flag high until write reaches oscillator domain
module watchdog_timer (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Processor state
    input wire logic idle_i,
    input wire logic debug_i,
    // Oscillator count clock pin
    input wire logic osc_clk_i,
    // Overflow outputs
    output logic overflow_interrupt_o,
    output logic nmi_cause_bit_zero_o,
    output logic wdt_reset_o,
    output logic irq_o
);

    logic osc_tick;
    logic [7:0] mode_ff;
    logic run_ff;
    logic mode_pend_ff;
    logic cmd_pend_ff;
    watchdog_pkg::cmd_kind_t cmd_kind_ff;
    logic [watchdog_pkg::CNT_WIDTH-1:0] cnt_ff;
    logic [watchdog_pkg::CNT_WIDTH-1:0] limit;
    logic counting;
    logic overflow;
    logic ovf_int_ff;
    logic [5:0] rst_cnt_ff;
    logic [watchdog_pkg::EVT_WIDTH-1:0] evt_status_ff;
    logic [watchdog_pkg::EVT_WIDTH-1:0] evt_mask_ff;
    logic [watchdog_pkg::EVT_WIDTH-1:0] evt_set;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_mode;
    logic wr_cmd;
    logic rd_status;
    logic wr_mask;
    logic apply_clear;
    logic apply_disable;
    logic apply_enable;
    logic ovf_nmi;
    logic ovf_rst;

    // Terminal count for a period code
    function automatic logic [watchdog_pkg::CNT_WIDTH-1:0] period_limit(
        input logic [2:0] sel
    );
        logic [watchdog_pkg::CNT_WIDTH-1:0] one;
        one = {{(watchdog_pkg::CNT_WIDTH-1){1'b0}}, 1'b1};
        unique case (sel)
            watchdog_pkg::PERIOD_2E15: period_limit = one << 15;
            watchdog_pkg::PERIOD_2E17: period_limit = one << 17;
            watchdog_pkg::PERIOD_2E19: period_limit = one << 19;
            watchdog_pkg::PERIOD_2E21: period_limit = one << 21;
            watchdog_pkg::PERIOD_2E23: period_limit = one << 23;
            // Prohibited codes fall back to the longest period
            default: period_limit = one << 25;
        endcase
    endfunction : period_limit

    // Strobe aimed at one register offset
    function automatic logic reg_hit(
        input logic strobe,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        reg_hit = strobe && (addr == ofs);
    endfunction : reg_hit

    osc_edge_sync u_osc_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .osc_clk_i(osc_clk_i),
        .tick_o(osc_tick)
    );

    assign wr_mode = reg_hit(wr_i, addr_i, watchdog_pkg::TIMER_MODE_OFS);
    assign wr_cmd = reg_hit(wr_i, addr_i, watchdog_pkg::COMMAND_CODE_OFS);
    assign wr_mask = reg_hit(wr_i, addr_i, watchdog_pkg::EVENT_MASK_OFS);
    assign rd_status = reg_hit(rd_i, addr_i, watchdog_pkg::EVENT_STATUS_OFS);

    // Mode register; its readback changes at once, the counter sees it at the next tick
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_ff <= watchdog_pkg::MODE_RESET; // R09
        end else if (wr_mode) begin
            mode_ff <= wdata_i[7:0] & watchdog_pkg::MODE_RW_MASK;
        end
    end

    // Pending transfer into the oscillator domain
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_pend_ff <= 1'b0;
        end else if (wr_mode) begin
            mode_pend_ff <= 1'b1; // R17
        end else if (osc_tick) begin
            mode_pend_ff <= 1'b0; // R17
        end
    end

    // Command capture; a reserved value is dropped at once
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmd_pend_ff <= 1'b0;
            cmd_kind_ff <= watchdog_pkg::CMD_NONE;
        end else if (wr_cmd && wdata_i[7:0] == watchdog_pkg::CMD_CLEAR) begin
            cmd_pend_ff <= 1'b1; // R17
            cmd_kind_ff <= watchdog_pkg::CMD_DO_CLEAR; // R05
        end else if (wr_cmd && wdata_i[7:0] == watchdog_pkg::CMD_DISABLE) begin
            cmd_pend_ff <= 1'b1; // R17
            cmd_kind_ff <= watchdog_pkg::CMD_DO_DISABLE; // R05
        end else if (osc_tick) begin
            cmd_pend_ff <= 1'b0; // R16
            cmd_kind_ff <= watchdog_pkg::CMD_NONE;
        end
    end

    // Pending writes act only on an oscillator tick, as in the count clock domain
    assign apply_clear = osc_tick && cmd_pend_ff
                         && (cmd_kind_ff == watchdog_pkg::CMD_DO_CLEAR); // R08
    assign apply_disable = osc_tick && cmd_pend_ff
                           && (cmd_kind_ff == watchdog_pkg::CMD_DO_DISABLE)
                           && !mode_ff[watchdog_pkg::ENABLE_BIT]; // R12
    assign apply_enable = osc_tick && mode_pend_ff && mode_ff[watchdog_pkg::ENABLE_BIT]; // R01

    // Run state: enabled by the mode bit, stopped only by the disable sequence
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            run_ff <= 1'b1; // R09
        end else if (apply_disable) begin
            run_ff <= 1'b0; // R12
        end else if (apply_enable) begin
            run_ff <= 1'b1; // R01
        end
    end

    assign limit = period_limit(mode_ff[watchdog_pkg::PERIOD_MSB:watchdog_pkg::PERIOD_LSB]); // R02

    // Idle and debug gate the counter; disabled counter stays put
    assign counting = run_ff && mode_ff[watchdog_pkg::ENABLE_BIT] // R01
                      && !debug_i // R10
                      && (!idle_i || mode_ff[watchdog_pkg::IDLE_RUN_BIT]); // R03

    assign overflow = osc_tick && counting && (cnt_ff == limit - 26'h0000001); // R07

    // Binary counter on oscillator edges
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_ff <= watchdog_pkg::CNT_RESET;
        end else if (apply_clear) begin
            cnt_ff <= watchdog_pkg::CNT_RESET; // R08
        end else if (apply_disable) begin
            cnt_ff <= watchdog_pkg::CNT_RESET; // R12
        end else if (overflow) begin
            cnt_ff <= watchdog_pkg::CNT_RESET;
        end else if (osc_tick && counting) begin
            cnt_ff <= cnt_ff + 26'h0000001; // R07
        end
    end

    // Overflow split by the action bit
    assign ovf_nmi = overflow && !mode_ff[watchdog_pkg::ACTION_BIT]; // R04
    assign ovf_rst = overflow && mode_ff[watchdog_pkg::ACTION_BIT]; // R04

    // Overflow interrupt pulse and its NMI cause strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ovf_int_ff <= 1'b0;
        end else begin
            ovf_int_ff <= ovf_nmi; // R04
        end
    end

    assign overflow_interrupt_o = ovf_int_ff; // R04
    assign nmi_cause_bit_zero_o = ovf_int_ff; // R15

    // Internal reset hold; restarted by a new overflow
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rst_cnt_ff <= 6'h00;
        end else if (ovf_rst) begin
            rst_cnt_ff <= watchdog_pkg::RST_HOLD_COUNT; // R11
        end else if (rst_cnt_ff != 6'h00) begin
            rst_cnt_ff <= rst_cnt_ff - 6'h01; // R11
        end
    end

    assign wdt_reset_o = (rst_cnt_ff != 6'h00); // R04

    // Sticky event bits; a new event beats the read that clears
    always_comb begin
        evt_set = '0;
        evt_set[watchdog_pkg::EVT_OVERFLOW_BIT] = ovf_nmi;
        evt_set[watchdog_pkg::EVT_RESET_BIT] = ovf_rst;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            evt_status_ff <= '0;
        end else if (rd_status) begin
            evt_status_ff <= evt_set;
        end else begin
            evt_status_ff <= evt_status_ff | evt_set;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            evt_mask_ff <= watchdog_pkg::EVT_MASK_RESET;
        end else if (wr_mask) begin
            evt_mask_ff <= wdata_i[watchdog_pkg::EVT_WIDTH-1:0];
        end
    end

    assign irq_o = |(evt_status_ff & evt_mask_ff);

    // Read mux; command register is write-only and reads zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (rd_i) begin
            unique case (addr_i)
                watchdog_pkg::TIMER_MODE_OFS: nxt_rdata[7:0] = mode_ff;
                watchdog_pkg::WRITE_LOCK_STATUS_OFS:
                    nxt_rdata[watchdog_pkg::PENDING_BIT] = mode_pend_ff | cmd_pend_ff; // R06
                watchdog_pkg::EVENT_STATUS_OFS:
                    nxt_rdata[watchdog_pkg::EVT_WIDTH-1:0] = evt_status_ff;
                watchdog_pkg::EVENT_MASK_OFS:
                    nxt_rdata[watchdog_pkg::EVT_WIDTH-1:0] = evt_mask_ff;
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;

endmodule : watchdog_timer

/* File: watchdog_pkg.sv */
// Shared constants for the watchdog timer: register map, fields, codes and counts
package watchdog_pkg;

    // Register byte offsets
    localparam logic [7:0] TIMER_MODE_OFS = 8'h00;
    localparam logic [7:0] COMMAND_CODE_OFS = 8'h04;
    localparam logic [7:0] WRITE_LOCK_STATUS_OFS = 8'h08;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'h0c;
    localparam logic [7:0] EVENT_MASK_OFS = 8'h10;

    // Mode register fields
    localparam int ENABLE_BIT = 7;
    localparam int PERIOD_LSB = 4;
    localparam int PERIOD_MSB = 6;
    localparam int IDLE_RUN_BIT = 2;
    localparam int ACTION_BIT = 1;
    localparam logic [7:0] MODE_RW_MASK = 8'hf6;
    localparam logic [7:0] MODE_RESET = 8'h82;

    // Flag register field
    localparam int PENDING_BIT = 0;

    // Event status and mask fields
    localparam int EVT_OVERFLOW_BIT = 0;
    localparam int EVT_RESET_BIT = 1;
    localparam int EVT_WIDTH = 2;
    localparam logic [1:0] EVT_MASK_RESET = 2'h0;

    // Command codes
    localparam logic [7:0] CMD_DISABLE = 8'hb1;
    localparam logic [7:0] CMD_CLEAR = 8'h4e;

    // Counter and reset pulse sizing
    localparam int CNT_WIDTH = 26;
    localparam logic [CNT_WIDTH-1:0] CNT_RESET = 26'h0000000;
    localparam int RST_HOLD_CYCLES = 32;
    localparam logic [5:0] RST_HOLD_COUNT = 6'(RST_HOLD_CYCLES);

    // Detect period codes
    localparam logic [2:0] PERIOD_2E15 = 3'h0;
    localparam logic [2:0] PERIOD_2E17 = 3'h1;
    localparam logic [2:0] PERIOD_2E19 = 3'h2;
    localparam logic [2:0] PERIOD_2E21 = 3'h3;
    localparam logic [2:0] PERIOD_2E23 = 3'h4;
    localparam logic [2:0] PERIOD_2E25 = 3'h5;

    // Pending command action
    typedef enum logic [2:0] {
        CMD_NONE = 3'b001,
        CMD_DO_CLEAR = 3'b010,
        CMD_DO_DISABLE = 3'b100
    } cmd_kind_t;

endpackage : watchdog_pkg

/* File: osc_edge_sync.sv */
// Two-stage synchroniser and rising-edge detector for the oscillator count clock
module osc_edge_sync (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Oscillator pin
    input wire logic osc_clk_i,
    // One-cycle pulse per oscillator rising edge
    output logic tick_o
);

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= osc_clk_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge seen only past the second stage
    assign tick_o = sync_ff & ~prev_ff;

endmodule : osc_edge_sync

/* File: watchdog_timer_asserts.sv */
// Checker for the watchdog register port and overflow outputs
module watchdog_timer_chk (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // Overflow outputs
    input wire logic overflow_interrupt_o,
    input wire logic nmi_cause_bit_zero_o,
    input wire logic wdt_reset_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // Cycles the reset request has stood so far
    logic [5:0] hold_cnt_ff;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !wdt_reset_o) begin
            hold_cnt_ff <= 6'h00;
        end else begin
            hold_cnt_ff <= hold_cnt_ff + 6'h01;
        end
    end
    property p_idle_zero; !rd_i |=> rdata_o == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero");
    property p_mode_bits; rd_i && addr_i == 8'h00 |=> (rdata_o & 32'hffffff09) == 32'h0; endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode fixed bits set");
    property p_cmd_zero; rd_i && addr_i == 8'h04 |=> rdata_o == 32'h0; endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
    property p_flag_bits; rd_i && addr_i == 8'h08 |=> rdata_o[31:1] == 31'h0; endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("flag upper bits set");
    property p_cause; overflow_interrupt_o == nmi_cause_bit_zero_o; endproperty
    a_cause: assert property (p_cause) else $error("cause strobe differs");
    property p_pulse; overflow_interrupt_o |=> !overflow_interrupt_o; endproperty
    a_pulse: assert property (p_pulse) else $error("interrupt pulse too long");
    property p_one_action; $rose(wdt_reset_o) |-> !overflow_interrupt_o; endproperty
    a_one_action: assert property (p_one_action) else $error("both actions at once");
    property p_hold_len; $fell(wdt_reset_o) |-> hold_cnt_ff == 6'h20; endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset length wrong");
    property p_hold_cap; wdt_reset_o |-> hold_cnt_ff < 6'h20; endproperty
    a_hold_cap: assert property (p_hold_cap) else $error("reset held too long");
    property p_status; rd_i && addr_i == 8'h0c && irq_o |=> rdata_o[1:0] != 2'h0; endproperty
    a_status: assert property (p_status) else $error("irq without status");
endmodule : watchdog_timer_chk

bind watchdog_timer watchdog_timer_chk watchdog_timer_chk_inst (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .overflow_interrupt_o(overflow_interrupt_o),
    .nmi_cause_bit_zero_o(nmi_cause_bit_zero_o),
    .wdt_reset_o(wdt_reset_o),
    .irq_o(irq_o)
);

/* File: tb.sv */
// Self-checking bench for the watchdog timer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic idle_i = 1'b0;
    logic debug_i = 1'b0;
    logic osc_clk_i = 1'b0;
    logic osc_run = 1'b0;
    logic [31:0] rdata_o;
    logic ovf, cause, wdt_rst, irq_o;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0;
    always #10 ref_clk_i = ~ref_clk_i;
    // Toggles on each rising clock edge, two clock cycles per count
    always @(posedge ref_clk_i) begin
        if (osc_run) begin
            osc_clk_i <= ~osc_clk_i;
        end
    end
    watchdog_timer watchdog_timer_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
        .debug_i(debug_i), .osc_clk_i(osc_clk_i), .overflow_interrupt_o(ovf),
        .nmi_cause_bit_zero_o(cause), .wdt_reset_o(wdt_rst), .irq_o(irq_o));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic irq_is(input logic e);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(32'(irq_o), 32'(e));
    endtask : irq_is
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(8'h00, 32'h82);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h0);
        rd(8'h00, 32'h82);
        $display("reset values done");
        wr(8'h00, 32'hff);
        rd(8'h00, 32'hf6);
        // Oscillator still, so the write cannot have landed yet
        rd(8'h08, 32'h1);
        osc_run <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        rd(8'h08, 32'h0);
        $display("write pending done");
        wr(8'h10, 32'h1);
        wr(8'h00, 32'h80);
        // Let the count build up so that a clear that did nothing shows
        repeat (2000) @(posedge ref_clk_i);
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h4e);
        t0 = cyc;
        debug_i <= 1'b1;
        repeat (2000) @(posedge ref_clk_i);
        debug_i <= 1'b0;
        idle_i <= 1'b1;
        repeat (2000) @(posedge ref_clk_i);
        idle_i <= 1'b0;
        repeat (2000) @(posedge ref_clk_i);
        // A reserved code that cleared would push overflow 2000 cycles late
        wr(8'h04, 32'h5a);
        do begin
            @(posedge ref_clk_i);
            #1;
        end while (ovf !== 1'b1);
        chk(32'(cyc - t0 > 69500 && cyc - t0 < 69580), 32'h1);
        chk(32'(cause), 32'h1);
        chk(32'(wdt_rst), 32'h0);
        irq_is(1'b1);
        wr(8'h10, 32'h0);
        irq_is(1'b0);
        wr(8'h10, 32'h1);
        irq_is(1'b1);
        rd(8'h0c, 32'h1);
        irq_is(1'b0);
        $display("overflow done");
        rd(8'h08, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'hb1);
        repeat (8) @(posedge ref_clk_i);
        rd(8'h08, 32'h0);
        // Deep sleep stops the count clock only once the disable has landed
        osc_run <= 1'b0;
        rd(8'h00, 32'h0);
        chk(32'(ovf), 32'h0);
        $display("disable done");
        give_verdict();
    end
endmodule : tb
